/* File: include/smcs_pkg.sv */
// Purpose: Shared constants and carriers for the servo mode/command select block
// Assumes: Signed 16-bit command words, one step per mV or r/min
// Notes:   AXI4-Lite register map lives here
package smcs_pkg;
    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0]  ADDR_CTRL      = 8'h00;
    localparam logic [7:0]  ADDR_TSCALE    = 8'h04;
    localparam logic [7:0]  ADDR_TOFFSET   = 8'h08;
    localparam logic [7:0]  ADDR_TLIM      = 8'h0c;
    localparam logic [7:0]  ADDR_ACCEL     = 8'h10;
    localparam logic [7:0]  ADDR_DECEL     = 8'h14;
    localparam logic [7:0]  ADDR_STATUS    = 8'h18;
    localparam logic [7:0]  ADDR_SPEED0    = 8'h20;
    localparam logic [7:0]  ADDR_SPEED_TOP = 8'h3c;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;
    // ------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------
    localparam int          CTRL_MODE_LSB  = 0;
    localparam int          CTRL_ABS_BIT   = 4;
    localparam int          CTRL_SP3_BIT   = 5;
    localparam logic [3:0]  MODE_POS_SPEED = 4'h1;
    localparam logic [3:0]  MODE_TORQUE    = 4'h4;
    // ------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------
    localparam logic [15:0] TSCALE_RESET   = 16'h1f40;
    localparam logic [15:0] TLIM_RESET     = 16'h7fff;
    localparam logic [15:0] OFFSET_MAX     = 16'h03e7;
    localparam logic [15:0] RAMP_RESET     = 16'h0001;
    localparam logic [15:0] SPEED_WINDOW   = 16'h0032;
    localparam logic [15:0] ZERO_WINDOW    = 16'h0032;
    localparam int          DEBOUNCE_NS    = 1000;
    localparam int          CLK_MHZ        = 100;
    localparam int          DEBOUNCE_CYC   = (DEBOUNCE_NS * CLK_MHZ + 999) / 1000;

    typedef enum logic [1:0] {
        SMCS_POS    = 2'b01,
        SMCS_SPEED  = 2'b10
    } smcs_ctl_e;

    typedef struct packed {
        logic fwd_rotation_select;
        logic rev_rotation_select;
        logic fwd_start;
        logic rev_start;
        logic speed_select_bit0;
        logic speed_select_bit1;
        logic speed_select_bit2;
        logic control_mode_change_in;
    } smcs_din_s;

    typedef struct packed {
        logic signed [15:0] torque_cmd;
        logic signed [15:0] speed_target;
        logic               clear_droop;
    } smcs_drive_s;
endpackage

/* File: hdl/smcs_top.sv */
// Purpose: Command selection and control-mode change for a servo amplifier
// Assumes: Analog inputs arrive already digitised on aclk; speed is signed r/min
// Notes:   Registers over AXI4-Lite; all outputs registered except the three AXI ready signals
//
// How it works
// - Torque sign: forward only keeps, reverse only inverts, else zero.
// - Scale register voltage gives full torque.
// - Offset clamped to plus/minus 999 mV added to torque command.
// - Torque clamped to forward limit one way, reverse the other.
// - Analog torque limit ignored in torque mode.
// - Speed limit direction follows rotation selections.
// - Three select bits: zero picks analog limit, else internal one to seven.
// - Limiting flag set when speed reaches active limit.
// - No position/speed change with absolute detection.
// - Mode input low picks position, high picks speed.
// - Mode changes only at zero speed.
// - Position to speed change clears droop count.
// - Edge seen away from zero speed is lost.
// - Two select bits: analog or internal commands one to three.
// - Third select bit, once assigned, widens choice to seven.
// - New speed reached by ramping at accel and decel rates.
// - Start inputs set direction; both or neither stop.
// - Reached flag set near the selected speed command.
`timescale 1ns/10ps
module smcs_top #(
    parameter int DEB_CYC = smcs_pkg::DEBOUNCE_CYC
) (
    input  wire logic                aclk,
    input  wire logic                aresetn,
    input  wire logic [7:0]          s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [7:0]          s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    input  wire smcs_pkg::smcs_din_s din_pins,
    input  wire logic signed [15:0]  analog_torque_cmd,
    input  wire logic signed [15:0]  analog_torque_limit,
    input  wire logic signed [15:0]  analog_speed_limit,
    input  wire logic signed [15:0]  analog_speed_cmd,
    input  wire logic signed [15:0]  motor_speed,
    output smcs_pkg::smcs_drive_s    drive,
    output logic                     speed_limiting_flag,
    output logic                     zero_speed_flag,
    output logic                     speed_reached_flag,
    output logic                     speed_mode_active
);
    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic        [5:0]  ctrl;
    logic        [15:0] tscale, toffset, fwd_lim, rev_lim, accel, decel;
    logic signed [15:0] spd_tab [1:7];
    logic aw_hold, w_hold;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic        next_aw_hold, next_w_hold, next_bvalid, next_rvalid;
    logic [7:0]  next_aw_addr;
    logic [31:0] next_w_data, next_rdata;
    logic [1:0]  next_bresp, next_rresp;
    logic        do_write;
    logic        wr_ok;
    logic [31:0] status_word;

    assign do_write = aw_hold && w_hold && !s_axi_bvalid;
    assign wr_ok    = (aw_addr <= smcs_pkg::ADDR_STATUS && aw_addr != smcs_pkg::ADDR_STATUS)
                   || (aw_addr > smcs_pkg::ADDR_SPEED0 && aw_addr <= smcs_pkg::ADDR_SPEED_TOP);

    always_comb
    begin
        next_aw_hold = aw_hold;
        next_w_hold  = w_hold;
        next_aw_addr = aw_addr;
        next_w_data  = w_data;
        next_bvalid  = s_axi_bvalid;
        next_bresp   = s_axi_bresp;
        next_rvalid  = s_axi_rvalid;
        next_rdata   = s_axi_rdata;
        next_rresp   = s_axi_rresp;
        if (s_axi_awvalid && s_axi_awready)
        begin
            next_aw_hold = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_w_hold = 1'b1;
            next_w_data = s_axi_wdata;
        end
        if (do_write)
        begin
            next_aw_hold = 1'b0;
            next_w_hold  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = (wr_ok && aw_addr[1:0] == 2'h0) ? smcs_pkg::RESP_OKAY : smcs_pkg::RESP_SLVERR;
        end
        else if (s_axi_bvalid && s_axi_bready)
            next_bvalid = 1'b0;
        if (s_axi_arvalid && s_axi_arready)
        begin
            next_rvalid = 1'b1;
            next_rresp  = smcs_pkg::RESP_OKAY;
            next_rdata  = 32'h0;
            unique case (s_axi_araddr)
                smcs_pkg::ADDR_CTRL:    next_rdata = {26'h0, ctrl};
                smcs_pkg::ADDR_TSCALE:  next_rdata = {16'h0, tscale};
                smcs_pkg::ADDR_TOFFSET: next_rdata = {16'h0, toffset};
                smcs_pkg::ADDR_TLIM:    next_rdata = {rev_lim, fwd_lim};
                smcs_pkg::ADDR_ACCEL:   next_rdata = {16'h0, accel};
                smcs_pkg::ADDR_DECEL:   next_rdata = {16'h0, decel};
                smcs_pkg::ADDR_STATUS:  next_rdata = status_word;
                default:
                begin
                    if (s_axi_araddr > smcs_pkg::ADDR_SPEED0 && s_axi_araddr <= smcs_pkg::ADDR_SPEED_TOP
                        && s_axi_araddr[1:0] == 2'h0)
                        next_rdata = {16'h0, spd_tab[s_axi_araddr[4:2]]};
                    else
                        next_rresp = smcs_pkg::RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
            next_rvalid = 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold      <= 1'b0;
            w_hold       <= 1'b0;
            aw_addr      <= 8'h0;
            w_data       <= 32'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= smcs_pkg::RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= smcs_pkg::RESP_OKAY;
        end
        else
        begin
            aw_hold      <= next_aw_hold;
            w_hold       <= next_w_hold;
            aw_addr      <= next_aw_addr;
            w_data       <= next_w_data;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp  <= next_bresp;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata  <= next_rdata;
            s_axi_rresp  <= next_rresp;
        end
    end

    // Ready is a pure function of the hold flags and of rvalid, so it comes straight from registered state
    assign s_axi_awready = !aw_hold;
    assign s_axi_wready  = !w_hold;
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl    <= {2'b00, smcs_pkg::MODE_TORQUE};
            tscale  <= smcs_pkg::TSCALE_RESET;
            toffset <= 16'h0;
            fwd_lim <= smcs_pkg::TLIM_RESET;
            rev_lim <= smcs_pkg::TLIM_RESET;
            accel   <= smcs_pkg::RAMP_RESET;
            decel   <= smcs_pkg::RAMP_RESET;
            for (int i = 1; i <= 7; i++)
                spd_tab[i] <= 16'sh0;
        end
        else if (do_write && wr_ok && aw_addr[1:0] == 2'h0)
        begin
            unique case (aw_addr)
                smcs_pkg::ADDR_CTRL:    ctrl    <= w_data[5:0];
                smcs_pkg::ADDR_TSCALE:  tscale  <= (w_data[15:0] == 16'h0) ? 16'h1 : w_data[15:0];
                smcs_pkg::ADDR_TOFFSET: toffset <= ($signed(w_data[15:0]) > $signed(smcs_pkg::OFFSET_MAX)) ?
                                           smcs_pkg::OFFSET_MAX :
                                           ($signed(w_data[15:0]) < -$signed(smcs_pkg::OFFSET_MAX)) ?
                                           (16'h0 - smcs_pkg::OFFSET_MAX) : w_data[15:0];
                smcs_pkg::ADDR_TLIM:
                begin
                    fwd_lim <= {1'b0, w_data[14:0]};
                    rev_lim <= {1'b0, w_data[30:16]};
                end
                smcs_pkg::ADDR_ACCEL:   accel   <= (w_data[15:0] == 16'h0) ? 16'h1 : w_data[15:0];
                smcs_pkg::ADDR_DECEL:   decel   <= (w_data[15:0] == 16'h0) ? 16'h1 : w_data[15:0];
                default:                spd_tab[aw_addr[4:2]] <= w_data[15:0];
            endcase
        end
    end

    // ------------------------------------------------------------
    // Input synchroniser and debounce
    // ------------------------------------------------------------
    smcs_pkg::smcs_din_s din_s1, din_s2, din_q;
    logic [7:0] deb_cnt [8];
    for (genvar b = 0; b < 8; b++)
    begin : g_deb
        logic [7:0] next_cnt;
        logic       next_q;
        always_comb
        begin
            next_cnt = deb_cnt[b];
            next_q   = din_q[b];
            if (din_s2[b] == din_q[b])
                next_cnt = 8'h0;
            else if (deb_cnt[b] >= 8'(DEB_CYC - 1))
            begin
                next_cnt = 8'h0;
                next_q   = din_s2[b];
            end
            else
                next_cnt = deb_cnt[b] + 8'h1;
        end
        always_ff @(posedge aclk)
        begin
            if (!aresetn)
            begin
                deb_cnt[b] <= 8'h0;
                din_q[b]   <= 1'b0;
            end
            else
            begin
                deb_cnt[b] <= next_cnt;
                din_q[b]   <= next_q;
            end
        end
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            din_s1 <= '0;
            din_s2 <= '0;
        end
        else
        begin
            din_s1 <= din_pins;
            din_s2 <= din_s1;
        end
    end

    // ------------------------------------------------------------
    // Mode change
    // ------------------------------------------------------------
    logic torque_mode, ps_mode, zero_now, lop_d, lop_edge;
    smcs_pkg::smcs_ctl_e ctl, next_ctl;
    logic next_clear;
    assign torque_mode = ctrl[3:0] == smcs_pkg::MODE_TORQUE;
    assign ps_mode     = ctrl[3:0] == smcs_pkg::MODE_POS_SPEED && !ctrl[smcs_pkg::CTRL_ABS_BIT];
    assign zero_now    = (motor_speed <= $signed(smcs_pkg::ZERO_WINDOW))
                      && (motor_speed >= -$signed(smcs_pkg::ZERO_WINDOW));
    assign lop_edge    = din_q.control_mode_change_in != lop_d;

    always_comb
    begin
        next_ctl   = ctl;
        next_clear = 1'b0;
        if (!ps_mode)
            next_ctl = smcs_pkg::SMCS_POS;
        // Edge-triggered: a level left pending while moving is never acted on
        else if (lop_edge && zero_speed_flag)
        begin
            next_ctl   = din_q.control_mode_change_in ? smcs_pkg::SMCS_SPEED : smcs_pkg::SMCS_POS;
            next_clear = (ctl == smcs_pkg::SMCS_POS) && din_q.control_mode_change_in;
        end
    end

    // ------------------------------------------------------------
    // Command paths
    // ------------------------------------------------------------
    logic [2:0]         sel;
    logic signed [15:0] sel_internal, lim, spd_cmd, ramp, next_ramp, step;
    logic signed [31:0] tq_wide;
    logic signed [15:0] tq_sat, next_tq;
    logic               rs_f, rs_r, st_f, st_r, next_limiting, next_reached, run;
    assign rs_f = din_q.fwd_rotation_select;
    assign rs_r = din_q.rev_rotation_select;
    assign st_f = din_q.fwd_start;
    assign st_r = din_q.rev_start;

    always_comb
    begin
        // Third bit always counts in torque mode, otherwise only once assigned to a pin
        sel = {din_q.speed_select_bit2 && (torque_mode || ctrl[smcs_pkg::CTRL_SP3_BIT]),
               din_q.speed_select_bit1, din_q.speed_select_bit0};
        sel_internal = (sel == 3'h0) ? 16'sh0 : spd_tab[sel];
        // Analog torque limit deliberately unused here
        tq_wide = ((32'(analog_torque_cmd) + 32'($signed(toffset))) * 32'sd32767)
                / 32'($signed({1'b0, tscale[14:0]}));
        if (rs_f == rs_r)
            tq_wide = 32'sh0;
        else if (rs_r)
            tq_wide = -tq_wide;
        if (tq_wide > 32'($signed(fwd_lim)))
            tq_sat = $signed(fwd_lim);
        else if (tq_wide < -32'($signed(rev_lim)))
            tq_sat = -$signed(rev_lim);
        else
            tq_sat = 16'(tq_wide);
        // Limit magnitude, signed to its acting direction
        lim = (sel == 3'h0) ? analog_speed_limit : sel_internal;
        if (rs_r && !rs_f)
            lim = -lim;
        next_limiting = torque_mode && (rs_f != rs_r) && (lim >= 0 ? motor_speed >= lim : motor_speed <= lim);
        // Speed command with start direction
        run     = ps_mode && ctl == smcs_pkg::SMCS_SPEED && (st_f != st_r);
        spd_cmd = (sel == 3'h0) ? analog_speed_cmd : sel_internal;
        if (!run)
            spd_cmd = 16'sh0;
        else if (st_r)
            spd_cmd = -spd_cmd;
        next_tq = torque_mode ? tq_sat : 16'sh0;
        // Ramp rate in r/min per cycle, magnitude moving away from zero uses accel
        step = ((ramp >= 0 && spd_cmd > ramp) || (ramp <= 0 && spd_cmd < ramp))
             ? $signed(accel) : $signed(decel);
        if (spd_cmd > ramp)
            next_ramp = (spd_cmd - ramp > step) ? 16'(ramp + step) : spd_cmd;
        else
            next_ramp = (ramp - spd_cmd > step) ? 16'(ramp - step) : spd_cmd;
        next_reached = run && (spd_cmd - motor_speed <= $signed(smcs_pkg::SPEED_WINDOW))
                    && (motor_speed - spd_cmd <= $signed(smcs_pkg::SPEED_WINDOW));
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            lop_d               <= 1'b0;
            ctl                 <= smcs_pkg::SMCS_POS;
            ramp                <= 16'sh0;
            drive               <= '0;
            speed_limiting_flag <= 1'b0;
            zero_speed_flag     <= 1'b0;
            speed_reached_flag  <= 1'b0;
            speed_mode_active   <= 1'b0;
        end
        else
        begin
            lop_d                  <= din_q.control_mode_change_in;
            ctl                    <= next_ctl;
            ramp                   <= next_ramp;
            drive.torque_cmd       <= next_tq;
            drive.speed_target     <= next_ramp;
            drive.clear_droop      <= next_clear;
            speed_limiting_flag    <= next_limiting;
            zero_speed_flag        <= zero_now;
            speed_reached_flag     <= next_reached;
            speed_mode_active      <= next_ctl == smcs_pkg::SMCS_SPEED;
        end
    end

    assign status_word = {25'h0, ctl == smcs_pkg::SMCS_SPEED, speed_reached_flag, zero_speed_flag,
                          speed_limiting_flag, din_q.control_mode_change_in, ps_mode, torque_mode};
endmodule

/* File: bench/smcs_properties.sv */
// Purpose: Port-level checks for smcs_top
// Assumes: One aclk domain, synchronous active-low reset
// Notes:   Bound into every smcs_top instance
`timescale 1ns/10ps
module smcs_properties #(
    parameter int DEB_CYC = 2
) (
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic                  s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic                  s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    input  wire logic [31:0]           s_axi_rdata,
    input  wire smcs_pkg::smcs_din_s   din_pins,
    input  wire smcs_pkg::smcs_drive_s drive,
    input  wire logic                  zero_speed_flag,
    input  wire logic                  speed_limiting_flag,
    input  wire logic                  speed_reached_flag,
    input  wire logic                  speed_mode_active
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ----------------------------------------
    // Run length of the raw mode input
    // ----------------------------------------
    logic [7:0] hi_cnt, next_hi_cnt;
    always_comb
    begin
        next_hi_cnt = hi_cnt;
        if (!din_pins.control_mode_change_in)
            next_hi_cnt = 8'h00;
        else if (hi_cnt != 8'hff)
            next_hi_cnt = hi_cnt + 8'h01;
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            hi_cnt <= 8'h00;
        else
            hi_cnt <= next_hi_cnt;
    end
    bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data moved before taken");
    droop_pulse_a: assert property (drive.clear_droop |=> !drive.clear_droop)
        else $error("droop clear longer than one cycle");
    droop_cause_a: assert property ($rose(speed_mode_active) |-> $past(drive.clear_droop) or ##[0:1] drive.clear_droop)
        else $error("speed mode entered without droop clear");
    zero_gate_a: assert property ($rose(speed_mode_active) |-> $past(zero_speed_flag) || $past(zero_speed_flag, 2))
        else $error("mode changed away from zero speed");
    debounce_a: assert property ($rose(speed_mode_active) |-> hi_cnt >= DEB_CYC)
        else $error("mode input acted before debounce");
    limit_mode_a: assert property (speed_limiting_flag && $past(speed_limiting_flag) |-> !speed_mode_active)
        else $error("limiting flag in speed control");
    reached_mode_a: assert property (speed_reached_flag && $past(speed_reached_flag) |-> speed_mode_active)
        else $error("reached flag outside speed control");
    mode_cov: cover property ($rose(speed_mode_active));
    limit_cov: cover property ($rose(speed_limiting_flag));
    reach_cov: cover property ($rose(speed_reached_flag));
endmodule
bind smcs_top smcs_properties #(.DEB_CYC(DEB_CYC)) u_props (.*);

/* File: bench/smcs_host_model.sv */
// Purpose: Host controller model driving the discrete inputs
// Assumes: Host moves the mode input only at zero speed
// Notes:   rude lets a test move it at speed on purpose
`timescale 1ns/10ps
module smcs_host_model (
    input  wire logic                aclk,
    input  wire logic                aresetn,
    input  wire smcs_pkg::smcs_din_s want,
    input  wire logic                rude,
    input  wire logic                zero_speed_flag,
    output smcs_pkg::smcs_din_s      din_pins
);
    smcs_pkg::smcs_din_s next_din_pins;
    always_comb
    begin
        next_din_pins = want;
        if (!zero_speed_flag && !rude)
            next_din_pins.control_mode_change_in = din_pins.control_mode_change_in;
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            din_pins <= '0;
        else
            din_pins <= next_din_pins;
    end
endmodule

/* File: bench/smcs_tb_top.sv */
// Purpose: Self-checking bench for smcs_top
// Assumes: Debounce shortened to 2 cycles, torque scale set to unity
// Notes:   Random analog values from a fixed seed
`timescale 1ns/10ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
    $display("ERROR %0t: mismatch got %h exp %h", $time, g, e); end end
module smcs_tb_top;
    localparam int SET = 12;
    logic aclk = 1'b0, aresetn = 1'b0, rude = 1'b0;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0, s_axi_arvalid = '0, s_axi_rready = '0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp, sel;
    smcs_pkg::smcs_din_s want = '0, din_pins;
    logic signed [15:0] analog_torque_cmd = '0, analog_torque_limit = '0, analog_speed_limit = '0;
    logic signed [15:0] analog_speed_cmd = '0, motor_speed = '0;
    smcs_pkg::smcs_drive_s drive;
    logic speed_limiting_flag, zero_speed_flag, speed_reached_flag, speed_mode_active;
    int num_errors = 0, samples_checked = 0, seed = 32'h13a65fd2, droops = 0, i, off, tq, lim, v, d0;
    smcs_top #(.DEB_CYC(2)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .din_pins,
        .analog_torque_cmd, .analog_torque_limit, .analog_speed_limit, .analog_speed_cmd, .motor_speed, .drive,
        .speed_limiting_flag, .zero_speed_flag, .speed_reached_flag, .speed_mode_active);
    smcs_host_model host (.aclk, .aresetn, .want, .rude, .zero_speed_flag, .din_pins);
    initial
    begin
        forever #5 aclk = ~aclk;
    end
    always @(posedge aclk) if (drive.clear_droop === 1'b1) droops++;
    // ----------------------------------------
    // Bus tasks, expectations, closing
    // ----------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = smcs_pkg::RESP_OKAY);
        logic got = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!got)
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            got = s_axi_bvalid;
        end
        s_axi_bready <= 1'b0;
        `CHK(s_axi_bresp, er)
    endtask
    task automatic rdr(input logic [7:0] a);
        logic got = 1'b0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!got)
        begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            got = s_axi_rvalid;
            rd = s_axi_rdata;
            rsp = s_axi_rresp;
        end
        s_axi_rready <= 1'b0;
    endtask
    function automatic logic signed [15:0] exp_tq(int c, int fl, int rl, logic f, logic r);
        int x;
        x = (f == r) ? 0 : (f ? c : -c);
        if (x > fl) x = fl;
        if (x < -rl) x = -rl;
        return 16'(x);
    endfunction
    task automatic test_done;
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        #100us;
        num_errors++;
        test_done();
    end
    task automatic settle;
        repeat (SET) @(posedge aclk);
    endtask
    initial
    begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rdr(smcs_pkg::ADDR_CTRL);
        `CHK(rd[3:0], smcs_pkg::MODE_TORQUE)
        rdr(smcs_pkg::ADDR_TSCALE);
        `CHK(rd[15:0], smcs_pkg::TSCALE_RESET)
        rdr(8'h1c);
        `CHK(rsp, smcs_pkg::RESP_SLVERR)
        wr(8'h40, '1, smcs_pkg::RESP_SLVERR);
        $display("registers done");
        wr(smcs_pkg::ADDR_TSCALE, 32'h7fff);
        wr(smcs_pkg::ADDR_TLIM, 32'h04b0_05dc);
        for (i = 0; i < 12; i++)
        begin
            off = (i == 11) ? 2000 : $random(seed) % 1000;
            tq = $random(seed) % 3000;
            wr(smcs_pkg::ADDR_TOFFSET, 32'(off));
            want <= {i[0], i[1], 6'h00};
            analog_torque_cmd <= 16'(tq);
            analog_torque_limit <= 16'($random(seed));
            settle();
            `CHK(drive.torque_cmd, exp_tq(tq + (off > 999 ? 999 : off), 1500, 1200, i[0], i[1]))
        end
        $display("torque done");
        for (i = 0; i < 8; i++)
        begin
            lim = 400 + 300 * i;
            if (i > 0) wr(smcs_pkg::ADDR_SPEED0 + 8'(4 * i), 32'(lim));
            analog_speed_limit <= (i == 0) ? 16'(lim) : 16'sh7000;
            want <= {!i[0], i[0], 2'b00, i[0], i[1], i[2], 1'b0};
            motor_speed <= 16'(i[0] ? -(lim + 200) : lim + 200);
            settle();
            `CHK(speed_limiting_flag, 1'b1)
            motor_speed <= 16'(i[0] ? 200 - lim : lim - 200);
            settle();
            `CHK(speed_limiting_flag, 1'b0)
        end
        $display("speed limit done");
        want <= '0;
        motor_speed <= '0;
        wr(smcs_pkg::ADDR_CTRL, 32'h11);
        want.control_mode_change_in <= 1'b1;
        settle();
        `CHK(speed_mode_active, 1'b0)
        want.control_mode_change_in <= 1'b0;
        wr(smcs_pkg::ADDR_CTRL, 32'h01);
        d0 = droops;
        want.control_mode_change_in <= 1'b1;
        settle();
        `CHK(speed_mode_active, 1'b1)
        `CHK(droops - d0, 1)
        want.control_mode_change_in <= 1'b0;
        settle();
        `CHK(speed_mode_active, 1'b0)
        motor_speed <= 16'sd1000;
        rude <= 1'b1;
        want.control_mode_change_in <= 1'b1;
        settle();
        `CHK(zero_speed_flag, 1'b0)
        motor_speed <= '0;
        rude <= 1'b0;
        settle();
        `CHK(zero_speed_flag, 1'b1)
        `CHK(speed_mode_active, 1'b0)
        want.control_mode_change_in <= 1'b0;
        settle();
        want.control_mode_change_in <= 1'b1;
        settle();
        `CHK(speed_mode_active, 1'b1)
        $display("mode change done");
        wr(smcs_pkg::ADDR_ACCEL, 32'h7fff);
        wr(smcs_pkg::ADDR_DECEL, 32'h7fff);
        for (i = 0; i < 16; i++)
        begin
            if (i % 8 == 0) wr(smcs_pkg::ADDR_CTRL, i[3] ? 32'h21 : 32'h01);
            sel = 2'($random(seed));
            tq = $random(seed) % 2000;
            analog_speed_cmd <= 16'(tq);
            want <= {2'b00, sel, i[0], i[1], i[2], 1'b1};
            lim = i[3] ? i % 8 : i % 4;
            v = (lim == 0) ? tq : 400 + 300 * lim;
            v = (sel[0] == sel[1]) ? 0 : (sel[1] ? v : -v);
            settle();
            `CHK(drive.speed_target, 16'(v))
            motor_speed <= 16'(v);
            settle();
            `CHK(speed_reached_flag, sel[0] != sel[1])
        end
        $display("speed command done");
        test_done();
    end
endmodule
